// *** rtl/dlrs_regs.vh ***
`ifndef DLRS_REGS_VH
`define DLRS_REGS_VH
// register byte offsets
`define DLRS_CTRL     8'h00
`define DLRS_STATUS   8'h04
`define DLRS_TXVWDIS  8'h08
`define DLRS_RXVWDIS  8'h0c
`define DLRS_MAXTRY   8'h10
`define DLRS_TXCRED   8'h14
`define DLRS_RXCRED   8'h18
// control fields
`define DLRS_C_START  0
`define DLRS_C_STOP   1
`define DLRS_C_TXCRST 2
`define DLRS_C_RXCRST 3
// status fields
`define DLRS_S_FAIL   8
// transmitter state codes
`define DLRS_TX_QUIET 2'b00
`define DLRS_TX_PSEND 2'b01
`define DLRS_TX_ACT   2'b11
// receiver state codes
`define DLRS_RX_IGN   2'b00
`define DLRS_RX_PSAMP 2'b01
`define DLRS_RX_HUNT  2'b10
`define DLRS_RX_ACT   2'b11
// reset values
`define DLRS_VWDIS_RST 32'hffffffff
`define DLRS_MAXTRY_RST 8'h08
`define DLRS_RXCRED_FULL 8'h20
`endif

// *** rtl/dlrs_top.v ***
// What this block does
// - Reset puts all link state into a defined link reset condition.
// - Hard reset anywhere spreads to every end of the link.
// - Transmitter link reset: quiet state, credit reset set, wire inputs disabled.
// - Quiet transmitter sends only frames full of idle packets.
// - Transmit credit counters stay zero while its credit reset is set.
// - Receiver link reset: ignore state, credit reset set, wire outputs disabled.
// - Ignoring receiver never loads its data capture registers.
// - Receive credit counters stay full while its credit reset is set.
// - Link reset anywhere spreads to every end of the link; FAR_LRST only starts shutdown, and only with tx active or rx hunting/active.
// - Registers stay accessible during link reset.
// - Receiver starts pattern sampling before transmitter starts pattern sending.
// - Alignment repeats; on failure everything returns to link reset.
// - After alignment transmitter goes quiet and clears its credit reset.
// - Receiver hunts only after idle frames arrive, then returns credits.
// - Transmitter goes active only once every receiver is hunting.
// - First non-idle frame starts at granule 0 of fragment 0.
// - Hunting receiver checks each bundle for sync frame, locks, goes active.
// - With all ends active, enable wire outputs first, then inputs.
// - Shutdown: disable inputs, finish frame, refuse packets, go quiet.
// - On idle frames in shutdown, disable wire outputs then ignore.
// - No credits cross link when quiet and ignoring; reset bits end it.
// - Fragments are taken on one common clock.
// - Transmitter state codes 00 quiet, 01 pattern send, 11 active.
// - Receiver state codes 00 ignore, 01 sample, 10 hunt, 11 active.
// - Clearing an input disable bit captures level and sends change packet.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`include "dlrs_regs.vh"
`default_nettype none
module dlrs_top (
  input  wire        CLK,
  input  wire        NRST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output wire        HREADYOUT,
  output wire        HRESP,
  input  wire        ALIGN_OK,
  input  wire        ALIGN_FAIL,
  input  wire        RX_IDLE_FRAME,
  input  wire        RX_BUNDLE_VALID,
  input  wire        RX_SYNC_SEEN,
  input  wire [63:0] RX_FRAG_DATA,
  input  wire        FAR_RX_HUNT,
  input  wire        FAR_RUN,
  input  wire        FAR_LRST,
  input  wire        TX_FRAME_BUSY,
  input  wire        TX_FRAME_START,
  input  wire        TX_PKT_VALID,
  output wire        TX_PKT_READY,
  input  wire        TX_CRED_ADD,
  input  wire        TX_CRED_USE,
  input  wire        RX_CRED_TAKE,
  input  wire        RX_CRED_FREE,
  input  wire [31:0] VW_IN,
  input  wire        WCP_READY,
  output reg         WCP_VALID,
  output reg  [4:0]  WCP_INDEX,
  output reg         WCP_LEVEL,
  output reg  [1:0]  TX_STATE,
  output reg  [1:0]  RX_STATE,
  output reg  [63:0] RX_DATA,
  output reg  [7:0]  TX_CREDITS,
  output reg  [7:0]  RX_CREDITS,
  output reg  [31:0] RX_VW_DIS,
  output wire        TX_IDLE_FILL,
  output wire        TX_PATTERN,
  output wire        RX_DESKEW_EN,
  output reg         RX_HDR_LOCK,
  output wire        CRED_XLINK_EN,
  output wire        RX_CRED_RET_EN,
  output wire        TX_LINK_RESET,
  output wire        RX_LINK_RESET,
  output reg         HRST_OUT
);
  // state codes exactly as software reads them in the status word;
  // the transmitter never uses code 10, so a stray value decodes as no state at all
  localparam [1:0] TX_QUIET = `DLRS_TX_QUIET;
  localparam [1:0] TX_PSEND = `DLRS_TX_PSEND;
  localparam [1:0] TX_ACT   = `DLRS_TX_ACT;
  localparam [1:0] RX_IGN   = `DLRS_RX_IGN;
  localparam [1:0] RX_PSAMP = `DLRS_RX_PSAMP;
  localparam [1:0] RX_HUNT  = `DLRS_RX_HUNT;
  localparam [1:0] RX_ACT   = `DLRS_RX_ACT;

  // virtual wire input disables and change tracking
  reg  [31:0] tx_vw_dis_reg;
  reg  [31:0] tx_vw_dis_next;
  reg  [31:0] vw_last_reg;
  reg  [31:0] vw_cap_reg;
  reg  [31:0] pend_reg;
  // register bus address phase and software settings
  reg  [7:0]  maxtry_reg;
  reg  [7:0]  try_reg;
  reg  [7:0]  a_addr_reg;
  reg         a_wr_reg;
  // sequencer state beside the two state fields
  reg         tx_crst_reg;
  reg         rx_crst_reg;
  reg         train_reg;
  reg         shut_reg;
  reg         fail_reg;
  reg         sync_pend_reg;
  reg  [1:0]  vw_phase_reg;
  wire [31:0] wd = HWDATA;
  wire        acc = HSEL & HTRANS[1] & HREADY;
  wire        wr = a_wr_reg;
  wire        wr_ctrl = wr & (a_addr_reg == `DLRS_CTRL);
  wire        start = wr_ctrl & wd[`DLRS_C_START];
  wire        stop = (wr_ctrl & wd[`DLRS_C_STOP]) | FAR_LRST;
  wire        tx_q = TX_STATE == TX_QUIET;
  wire        tx_a = TX_STATE == TX_ACT;
  wire        tx_ps = TX_STATE == TX_PSEND;
  // decoded receiver states, shared by the sequencer and the status outputs
  wire        rx_ign = RX_STATE == RX_IGN;
  wire        rx_psamp = RX_STATE == RX_PSAMP;
  wire        rx_hunt = RX_STATE == RX_HUNT;
  wire        rx_act = RX_STATE == RX_ACT;
  wire        rx_up = RX_STATE[1];
  // one name per condition so the sequencer and the disable logic cannot drift apart
  wire        vw_go = tx_a & rx_act & FAR_RUN & ~shut_reg;
  wire        shut_go = stop & (tx_a | rx_up);
  // credit reset bits written this cycle, seen by the counters at the same edge
  wire        tx_crst_set = wr_ctrl & wd[`DLRS_C_TXCRST];
  wire        rx_crst_set = wr_ctrl & wd[`DLRS_C_RXCRST];
  wire        give_up = ALIGN_FAIL & (try_reg + 8'h01 >= maxtry_reg);

  // lowest set bit of a 32-bit word
  function [4:0] first_set;
    input [31:0] v;
    integer i;
    begin
      first_set = 5'h00;
      for (i = 31; i >= 0; i = i - 1)
        if (v[i]) first_set = i[4:0];
    end
  endfunction

  // zero wait state slave, always OKAY; registers never gated by link state
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  assign TX_LINK_RESET = tx_q & tx_crst_reg & (&tx_vw_dis_reg);
  assign RX_LINK_RESET = rx_ign & rx_crst_reg & (&RX_VW_DIS);
  assign TX_IDLE_FILL = tx_q;
  assign TX_PATTERN = tx_ps;
  assign RX_DESKEW_EN = ~rx_ign;
  // the sync frame is only accepted on a frame slot aligned to granule 0
  assign TX_PKT_READY = tx_a & ~shut_reg & (~sync_pend_reg | TX_FRAME_START);
  assign CRED_XLINK_EN = tx_a & rx_up;
  assign RX_CRED_RET_EN = ~rx_crst_reg & rx_up;

  // address phase capture and registered read data
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      a_wr_reg <= 1'b0;
      a_addr_reg <= 8'h00;
      HRDATA <= 32'h00000000;
    end else begin
      a_wr_reg <= acc & HWRITE;
      a_addr_reg <= HADDR[7:0];
      if (acc & ~HWRITE) begin
        case (HADDR[7:0])
          `DLRS_CTRL:    HRDATA <= {28'h0000000, rx_crst_reg, tx_crst_reg, 2'b00};
          `DLRS_STATUS:  HRDATA <= {23'h000000, fail_reg, 1'b0, RX_HDR_LOCK,
                                    RX_LINK_RESET, TX_LINK_RESET, RX_STATE, TX_STATE};
          `DLRS_TXVWDIS: HRDATA <= tx_vw_dis_reg;
          `DLRS_RXVWDIS: HRDATA <= RX_VW_DIS;
          `DLRS_MAXTRY:  HRDATA <= {24'h000000, maxtry_reg};
          `DLRS_TXCRED:  HRDATA <= {24'h000000, TX_CREDITS};
          `DLRS_RXCRED:  HRDATA <= {24'h000000, RX_CREDITS};
          default:       HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // hard reset indication held through reset, dropped one edge after release
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) HRST_OUT <= 1'b1;
    else HRST_OUT <= 1'b0;
  end

  // training and link sequencer
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TX_STATE <= `DLRS_TX_QUIET;
      RX_STATE <= `DLRS_RX_IGN;
      tx_crst_reg <= 1'b1;
      rx_crst_reg <= 1'b1;
      train_reg <= 1'b0;
      shut_reg <= 1'b0;
      try_reg <= 8'h00;
      maxtry_reg <= `DLRS_MAXTRY_RST;
      fail_reg <= 1'b0;
      RX_HDR_LOCK <= 1'b0;
      sync_pend_reg <= 1'b0;
      vw_phase_reg <= 2'b00;
      RX_VW_DIS <= `DLRS_VWDIS_RST;
    end else begin
      // software side first, sequencer events below take precedence
      if (wr_ctrl) begin
        tx_crst_reg <= wd[`DLRS_C_TXCRST];
        rx_crst_reg <= wd[`DLRS_C_RXCRST];
      end
      if (wr & (a_addr_reg == `DLRS_MAXTRY)) maxtry_reg <= wd[7:0];
      if (wr & (a_addr_reg == `DLRS_RXVWDIS)) RX_VW_DIS <= wd;
      if (wr & (a_addr_reg == `DLRS_STATUS) & wd[`DLRS_S_FAIL]) fail_reg <= 1'b0;
      // receiver first, transmitter follows a cycle later
      if (start & tx_q & (RX_STATE == `DLRS_RX_IGN)) begin
        RX_STATE <= `DLRS_RX_PSAMP;
        train_reg <= 1'b1;
        try_reg <= 8'h00;
      end
      if (train_reg & tx_q & (RX_STATE == `DLRS_RX_PSAMP))
        TX_STATE <= `DLRS_TX_PSEND;
      if (TX_STATE == `DLRS_TX_PSEND) begin
        if (ALIGN_OK) begin
          TX_STATE <= `DLRS_TX_QUIET;
          tx_crst_reg <= 1'b0;
          train_reg <= 1'b0;
        end else if (give_up) begin
          TX_STATE <= `DLRS_TX_QUIET;
          RX_STATE <= `DLRS_RX_IGN;
          tx_crst_reg <= 1'b1;
          rx_crst_reg <= 1'b1;
          train_reg <= 1'b0;
          fail_reg <= 1'b1;
        end else if (ALIGN_FAIL)
          try_reg <= try_reg + 8'h01;
      end
      // wait for idle frames before hunting
      if (rx_psamp & ~train_reg & RX_IDLE_FRAME) begin
        RX_STATE <= `DLRS_RX_HUNT;
        rx_crst_reg <= 1'b0;
      end
      if (tx_q & ~tx_crst_reg & ~shut_reg & rx_up & FAR_RX_HUNT) begin
        TX_STATE <= `DLRS_TX_ACT;
        sync_pend_reg <= 1'b1;
      end
      if (TX_PKT_VALID & TX_PKT_READY) sync_pend_reg <= 1'b0;
      if (rx_hunt & RX_BUNDLE_VALID & RX_SYNC_SEEN) begin
        RX_STATE <= `DLRS_RX_ACT;
        RX_HDR_LOCK <= 1'b1;
      end
      // wire enables: outputs first, inputs on the next cycle
      if (vw_go) begin
        if (vw_phase_reg == 2'b00) begin
          RX_VW_DIS <= 32'h00000000;
          vw_phase_reg <= 2'b01;
        end else if (vw_phase_reg == 2'b01)
          vw_phase_reg <= 2'b10;
      end
      // shutdown towards link reset
      if (shut_go) begin
        shut_reg <= 1'b1;
        vw_phase_reg <= 2'b00;
      end
      if (tx_a & shut_reg & ~TX_FRAME_BUSY) begin
        TX_STATE <= `DLRS_TX_QUIET;
        sync_pend_reg <= 1'b0;
      end
      if (rx_up & shut_reg & RX_IDLE_FRAME) begin
        if (&RX_VW_DIS) begin
          RX_STATE <= `DLRS_RX_IGN;
          RX_HDR_LOCK <= 1'b0;
        end else
          RX_VW_DIS <= `DLRS_VWDIS_RST;
      end
      if (shut_reg & tx_q & (RX_STATE == `DLRS_RX_IGN)) shut_reg <= 1'b0;
    end
  end

  // input disable bits: software, shutdown forcing and the enable sequence
  always @* begin
    tx_vw_dis_next = tx_vw_dis_reg;
    if (wr & (a_addr_reg == `DLRS_TXVWDIS)) tx_vw_dis_next = wd;
    if (vw_go & (vw_phase_reg == 2'b01))
      tx_vw_dis_next = 32'h00000000;
    if (shut_go) tx_vw_dis_next = `DLRS_VWDIS_RST;
  end

  // wire change tracking; a new event on the slot being sent re-arms it
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_vw_dis_reg <= `DLRS_VWDIS_RST;
      vw_last_reg <= 32'h00000000;
      vw_cap_reg <= 32'h00000000;
      pend_reg <= 32'h00000000;
      WCP_VALID <= 1'b0;
      WCP_INDEX <= 5'h00;
      WCP_LEVEL <= 1'b0;
    end else begin
      tx_vw_dis_reg <= tx_vw_dis_next;
      vw_last_reg <= VW_IN;
      if (!WCP_VALID || WCP_READY) begin
        WCP_VALID <= |pend_reg;
        WCP_INDEX <= first_set(pend_reg);
        WCP_LEVEL <= vw_cap_reg[first_set(pend_reg)];
        pend_reg <= (pend_reg & ~((|pend_reg) ? (32'h00000001 << first_set(pend_reg))
                    : 32'h00000000))
                    | (tx_vw_dis_reg & ~tx_vw_dis_next)
                    | (~tx_vw_dis_reg & (VW_IN ^ vw_last_reg));
      end else
        pend_reg <= pend_reg | (tx_vw_dis_reg & ~tx_vw_dis_next)
                    | (~tx_vw_dis_reg & (VW_IN ^ vw_last_reg));
      // level captured when a bit is enabled or an enabled wire moves
      vw_cap_reg <= ((tx_vw_dis_reg & ~tx_vw_dis_next) | ~tx_vw_dis_reg) & VW_IN
                    | (tx_vw_dis_reg & tx_vw_dis_next & vw_cap_reg);
    end
  end

  // credit counters and receive data capture on the common clock
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TX_CREDITS <= 8'h00;
      RX_CREDITS <= `DLRS_RXCRED_FULL;
      RX_DATA <= 64'h0000000000000000;
    end else begin
      // a reset bit written now clears at this same edge, so link reset status after a write
      // never shows a stale count; a reset bit set by give_up clears the count one edge later
      if (tx_crst_reg | tx_crst_set) TX_CREDITS <= 8'h00;
      else TX_CREDITS <= TX_CREDITS + {7'h00, TX_CRED_ADD} - {7'h00, TX_CRED_USE};
      if (rx_crst_reg | rx_crst_set) RX_CREDITS <= `DLRS_RXCRED_FULL;
      else RX_CREDITS <= RX_CREDITS - {7'h00, RX_CRED_TAKE} + {7'h00, RX_CRED_FREE};
      // slice fragments arrive already on this clock; no load while ignoring
      if (RX_BUNDLE_VALID & (RX_STATE != `DLRS_RX_IGN))
        RX_DATA <= RX_FRAG_DATA;
    end
  end
endmodule // dlrs_top
`default_nettype wire

// *** test/dlrs_props.sv ***
`include "dlrs_regs.vh"
`default_nettype none
module dlrs_props (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        RX_IDLE_FRAME,
  input wire logic        RX_BUNDLE_VALID,
  input wire logic        RX_SYNC_SEEN,
  input wire logic        FAR_RX_HUNT,
  input wire logic        FAR_RUN,
  input wire logic [1:0]  TX_STATE,
  input wire logic [1:0]  RX_STATE,
  input wire logic [63:0] RX_DATA,
  input wire logic [7:0]  TX_CREDITS,
  input wire logic [7:0]  RX_CREDITS,
  input wire logic [31:0] RX_VW_DIS,
  input wire logic        TX_IDLE_FILL,
  input wire logic        RX_HDR_LOCK,
  input wire logic        TX_LINK_RESET,
  input wire logic        RX_LINK_RESET
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // a bundle carrying the sync frame while hunting
  sequence sync_hit;
    RX_STATE == `DLRS_RX_HUNT && RX_BUNDLE_VALID && RX_SYNC_SEEN;
  endsequence
  chk_tx_lrst_hold: assert property (
    TX_LINK_RESET |-> TX_STATE == `DLRS_TX_QUIET && TX_CREDITS == 8'h00)
    else $error("tx link reset with wrong state or credits");
  chk_rx_lrst_hold: assert property (
    RX_LINK_RESET |-> RX_STATE == `DLRS_RX_IGN && RX_CREDITS == `DLRS_RXCRED_FULL && &RX_VW_DIS)
    else $error("rx link reset with wrong state, credits or disables");
  chk_ignore_noload: assert property (
    RX_STATE == `DLRS_RX_IGN |=> $stable(RX_DATA))
    else $error("rx data loaded while ignoring");
  chk_quiet_idle: assert property (
    TX_STATE == `DLRS_TX_QUIET |-> TX_IDLE_FILL)
    else $error("quiet transmitter not sending idle frames");
  chk_train_order: assert property (
    TX_STATE == `DLRS_TX_PSEND |-> RX_STATE == `DLRS_RX_PSAMP)
    else $error("pattern send without receiver sampling");
  chk_hunt_entry: assert property (
    RX_STATE == `DLRS_RX_HUNT && $past(RX_STATE) == `DLRS_RX_PSAMP |-> $past(RX_IDLE_FRAME))
    else $error("hunt entered without idle frames");
  chk_run_gate: assert property (
    TX_STATE == `DLRS_TX_ACT && $past(TX_STATE) != `DLRS_TX_ACT
      |-> $past(FAR_RX_HUNT && RX_STATE[1]))
    else $error("transmitter active before receivers hunt");
  chk_sync_lock: assert property (
    sync_hit |=> RX_STATE == `DLRS_RX_ACT && RX_HDR_LOCK)
    else $error("sync frame did not lock header");
  chk_wire_order: assert property (
    $fell(&RX_VW_DIS)
      |-> $past(TX_STATE == `DLRS_TX_ACT && RX_STATE == `DLRS_RX_ACT && FAR_RUN))
    else $error("wire outputs enabled before all ends active");
endmodule // dlrs_props
bind dlrs_top dlrs_props chk_u (.CLK(CLK), .NRST(NRST), .RX_IDLE_FRAME(RX_IDLE_FRAME),
  .RX_BUNDLE_VALID(RX_BUNDLE_VALID), .RX_SYNC_SEEN(RX_SYNC_SEEN), .FAR_RX_HUNT(FAR_RX_HUNT),
  .FAR_RUN(FAR_RUN), .TX_STATE(TX_STATE), .RX_STATE(RX_STATE), .RX_DATA(RX_DATA),
  .TX_CREDITS(TX_CREDITS), .RX_CREDITS(RX_CREDITS), .RX_VW_DIS(RX_VW_DIS),
  .TX_IDLE_FILL(TX_IDLE_FILL), .RX_HDR_LOCK(RX_HDR_LOCK), .TX_LINK_RESET(TX_LINK_RESET),
  .RX_LINK_RESET(RX_LINK_RESET));
`default_nettype wire

// *** test/dlrs_far_model.sv ***
`include "dlrs_regs.vh"
`default_nettype none
module dlrs_far_model (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       no_align,
  input wire logic [1:0] tx_state,
  input wire logic [1:0] rx_state,
  output var logic       align_ok,
  output var logic       idle_frame,
  output var logic       far_hunt,
  output var logic       far_run,
  output var logic       bundle_valid,
  output var logic       sync_seen,
  output var logic       frame_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // far die reacts one cycle late to what the near side shows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {align_ok, idle_frame, far_hunt, far_run} <= 4'h0;
      {bundle_valid, sync_seen, frame_start} <= 3'h0;
    end else begin
      align_ok <= !no_align && tx_state == `DLRS_TX_PSEND && !align_ok;
      idle_frame <= tx_state == `DLRS_TX_QUIET;
      far_hunt <= tx_state == `DLRS_TX_QUIET && rx_state != `DLRS_RX_IGN;
      far_run <= tx_state == `DLRS_TX_ACT && rx_state == `DLRS_RX_ACT;
      bundle_valid <= !bundle_valid; // bundles keep coming even when ignored
      sync_seen <= rx_state == `DLRS_RX_HUNT;
      frame_start <= !frame_start;
    end
  end
endmodule // dlrs_far_model
`default_nettype wire

// *** test/testbench.sv ***
`include "dlrs_regs.vh"
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 400) begin @(posedge CLK); k++; end \
  if (!(c)) begin n_mismatch++; $display("CHECK FAILED wait exp 1 got 0"); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, NRST, HWRITE, HREADYOUT, HRESP, ALIGN_FAIL, busy, no_align;
  logic        ALIGN_OK, IDLE, FHUNT, FRUN, BVAL, SYNC, FSTART, PREADY, WCP_VALID, WCP_LEVEL;
  logic        LOCK, TXLR, RXLR, tpat, dsk, xl, hrst, cret;
  logic [1:0]  HTRANS, TX_STATE, RX_STATE;
  logic [3:0]  cred;
  logic [4:0]  WCP_INDEX;
  logic [7:0]  TXC, RXC;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, VW_IN, RX_VW_DIS;
  logic [63:0] frag, RX_DATA;
  int          n_mismatch, comparisons, k, cyc;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] re [8] = '{32'hc, 32'h30, '1, '1, 32'h8, 32'h0, 32'h20, 32'h0};
  dlrs_top dut_u (.CLK(CLK), .NRST(NRST), .HSEL(1'b1), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ALIGN_OK(ALIGN_OK), .ALIGN_FAIL(ALIGN_FAIL),
    .RX_IDLE_FRAME(IDLE), .RX_BUNDLE_VALID(BVAL), .RX_SYNC_SEEN(SYNC), .RX_FRAG_DATA(frag),
    .FAR_RX_HUNT(FHUNT), .FAR_RUN(FRUN), .FAR_LRST(1'b0), .TX_FRAME_BUSY(busy),
    .TX_FRAME_START(FSTART), .TX_PKT_VALID(1'b1), .TX_PKT_READY(PREADY),
    .TX_CRED_ADD(cred[0]), .TX_CRED_USE(cred[1]), .RX_CRED_TAKE(cred[2]),
    .RX_CRED_FREE(cred[3]), .VW_IN(VW_IN), .WCP_READY(1'b1), .WCP_VALID(WCP_VALID),
    .WCP_INDEX(WCP_INDEX), .WCP_LEVEL(WCP_LEVEL), .TX_STATE(TX_STATE), .RX_STATE(RX_STATE),
    .RX_DATA(RX_DATA), .TX_CREDITS(TXC), .RX_CREDITS(RXC), .RX_VW_DIS(RX_VW_DIS),
    .TX_IDLE_FILL(), .TX_PATTERN(tpat), .RX_DESKEW_EN(dsk), .RX_HDR_LOCK(LOCK),
    .CRED_XLINK_EN(xl), .RX_CRED_RET_EN(cret), .TX_LINK_RESET(TXLR), .RX_LINK_RESET(RXLR),
    .HRST_OUT(hrst));
  dlrs_far_model far_u (.clk(CLK), .nrst(NRST), .no_align(no_align), .tx_state(TX_STATE),
    .rx_state(RX_STATE), .align_ok(ALIGN_OK), .idle_frame(IDLE), .far_hunt(FHUNT),
    .far_run(FRUN), .bundle_valid(BVAL), .sync_seen(SYNC), .frame_start(FSTART));
  // one single word transfer, held until hready is seen at each phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'b10;
    @(posedge CLK);
    while (!HREADYOUT) @(posedge CLK);
    HTRANS <= 2'b00;
    HWDATA <= d;
    @(posedge CLK);
    while (!HREADYOUT) @(posedge CLK);
    rd = HRDATA;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // hang guard and moving fragment data
  always @(posedge CLK) begin
    cyc++;
    frag <= frag + 64'h1;
    if (cyc == 8000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {NRST, HWRITE, ALIGN_FAIL, busy, no_align, HTRANS, cred} = '0;
    {HADDR, HWDATA, frag} = '0;
    VW_IN = 32'h00000005;
    repeat (6) @(posedge CLK);
    `CHK("hard reset out", 1'b1, hrst)
    NRST <= 1'b1;
    cred <= 4'b0101; // credit events that must not move held counters
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 32'h0);
      `CHK("reset reg", re[i], rd)
    end
    cred <= 4'h0;
    `CHK("hresp", 1'b0, HRESP)
    `CHK("hard reset released", 1'b0, hrst)
    $display("test reset values done");
    bus(1'b1, `DLRS_CTRL, 32'hd);
    `WAIT(TX_STATE == `DLRS_TX_PSEND)
    `CHK("rx sampling", `DLRS_RX_PSAMP, RX_STATE)
    `CHK("pattern out", 1'b1, tpat)
    `CHK("deskew on", 1'b1, dsk)
    `WAIT(RX_STATE == `DLRS_RX_HUNT)
    `CHK("tx quiet", `DLRS_TX_QUIET, TX_STATE)
    `CHK("credit return", 1'b1, cret)
    `WAIT(RX_STATE == `DLRS_RX_ACT)
    `CHK("hdr lock", 1'b1, LOCK)
    `CHK("tx active", `DLRS_TX_ACT, TX_STATE)
    `CHK("credits cross", 1'b1, xl)
    `WAIT(RX_VW_DIS == 32'h0)
    `WAIT(WCP_VALID)
    `CHK("wcp index", 5'h00, WCP_INDEX)
    `CHK("wcp level", 1'b1, WCP_LEVEL)
    bus(1'b0, `DLRS_TXVWDIS, 32'h0);
    `CHK("tx inputs on", 32'h0, rd)
    cred <= 4'b0101;
    @(posedge CLK);
    cred <= 4'h0;
    @(posedge CLK);
    `CHK("tx credit add", 8'h01, TXC)
    `CHK("rx credit take", `DLRS_RXCRED_FULL - 8'h01, RXC)
    $display("test bring up done");
    busy <= 1'b1;
    bus(1'b1, `DLRS_CTRL, 32'h2);
    repeat (3) @(posedge CLK);
    `CHK("tx finishing", `DLRS_TX_ACT, TX_STATE)
    `CHK("pkt refused", 1'b0, PREADY)
    busy <= 1'b0;
    `WAIT(TX_STATE == `DLRS_TX_QUIET)
    `WAIT(&RX_VW_DIS)
    `CHK("rx still up", `DLRS_RX_ACT, RX_STATE)
    `WAIT(RX_STATE == `DLRS_RX_IGN)
    bus(1'b0, `DLRS_TXVWDIS, 32'h0);
    `CHK("tx inputs off", 32'hffffffff, rd)
    bus(1'b1, `DLRS_CTRL, 32'hc);
    bus(1'b0, `DLRS_STATUS, 32'h0);
    `CHK("status lrst", 32'h30, rd)
    `CHK("no credits cross", 1'b0, xl)
    `CHK("tx credits reset", 8'h00, TXC)
    `CHK("rx credits reset", `DLRS_RXCRED_FULL, RXC)
    $display("test shutdown done");
    no_align <= 1'b1;
    bus(1'b1, `DLRS_MAXTRY, 32'h2);
    bus(1'b1, `DLRS_CTRL, 32'hd);
    `WAIT(TX_STATE == `DLRS_TX_PSEND)
    for (int i = 0; i < 2; i++) begin
      ALIGN_FAIL <= 1'b1;
      @(posedge CLK);
      ALIGN_FAIL <= 1'b0;
      repeat (2) @(posedge CLK);
      `CHK("fail retry", i ? `DLRS_TX_QUIET : `DLRS_TX_PSEND, TX_STATE)
    end
    bus(1'b0, `DLRS_STATUS, 32'h0);
    `CHK("fail flag", 32'h130, rd)
    bus(1'b1, `DLRS_STATUS, 32'h100);
    bus(1'b0, `DLRS_STATUS, 32'h0);
    `CHK("fail clear", 32'h30, rd)
    $display("test align failure done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
